// *** rtl/uet_pkg.sv ***
package uet_pkg;
  // Register byte offsets
  localparam logic [11:0] ENV_OFS    = 12'h000;
  localparam logic [11:0] TMO_OFS    = 12'h004;
  localparam logic [11:0] MISC_OFS   = 12'h008;
  localparam logic [11:0] STAT_OFS   = 12'h00C;
  localparam logic [11:0] MASK_OFS   = 12'h010;
  // Envelope fields
  localparam int          ENV_W      = 4;
  localparam int          ENV_M_LSB  = 0;
  localparam int          ENV_S_LSB  = 8;
  localparam logic [3:0]  ENV_RST    = 4'h0;
  // Timeout field
  localparam int          TMO_W      = 18;
  localparam logic [17:0] TMO_RST    = 18'h0_0000;
  // Control and event bits
  localparam int          OVR_BIT    = 0;
  localparam int          EV_TMO     = 0;
  localparam int          EV_ENV     = 1;
  localparam int          EV_W       = 2;
  localparam logic [1:0]  EV_RST     = 2'h0;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ENV   = 3'b010,
    ST_BURST = 3'b100
  } uet_state_t;
endpackage : uet_pkg

// *** rtl/uet_top.sv ***
`timescale 1ns/1ps
module uet_top #(
  parameter logic [3:0] DEFAULT_ENV = 4'h3
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        burst_start_i,
  input  wire logic        burst_data_in_i,
  input  wire logic        burst_slave_i,
  input  wire logic        burst_end_i,
  input  wire logic        pio_wait_i,
  input  wire logic        io_ready_i,
  output logic             dma_acknowledge_pin_n_o,
  output logic             host_write_strobe_n_o,
  output logic             host_read_strobe_n_o,
  output logic             pio_timeout_o,
  output logic             irq_o
);

  logic [3:0]             master_envelope_count;
  logic [3:0]             slave_envelope_count;
  logic [17:0]            tmo_limit;
  logic                   timing_override_bit;
  logic [1:0]             irq_status;
  logic [1:0]             irq_mask;
  logic [1:0]             ev_set;
  uet_pkg::uet_state_t    state;
  logic [3:0]             env_cnt;
  logic                   dir_in;
  logic [17:0]            tmo_cnt;
  logic                   tmo_fired;
  logic                   wr_en;
  logic                   rd_setup;
  logic                   env_done;
  logic [3:0]             next_env;
  logic [31:0]            next_rdata;
  logic                   next_err;

  assign wr_en    = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_setup = psel_i & ~penable_i;
  assign env_done = (state == uet_pkg::ST_ENV) && (env_cnt == 4'h0);

  always_comb begin
    if (!timing_override_bit) begin
      next_env = DEFAULT_ENV;
    end else if (burst_slave_i) begin
      next_env = slave_envelope_count;
    end else begin
      next_env = master_envelope_count;
    end
  end

  // Register file; reserved bits are never stored
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      master_envelope_count <= uet_pkg::ENV_RST;
      slave_envelope_count  <= uet_pkg::ENV_RST;
      tmo_limit             <= uet_pkg::TMO_RST;
      timing_override_bit   <= 1'b0;
      irq_mask              <= uet_pkg::EV_RST;
    end else if (wr_en) begin
      if (paddr_i == uet_pkg::ENV_OFS) begin
        master_envelope_count <=
          pwdata_i[uet_pkg::ENV_M_LSB +: uet_pkg::ENV_W];
        slave_envelope_count  <=
          pwdata_i[uet_pkg::ENV_S_LSB +: uet_pkg::ENV_W];
      end else if (paddr_i == uet_pkg::TMO_OFS) begin
        tmo_limit <= pwdata_i[uet_pkg::TMO_W-1:0];
      end else if (paddr_i == uet_pkg::MISC_OFS) begin
        timing_override_bit <= pwdata_i[uet_pkg::OVR_BIT];
      end else if (paddr_i == uet_pkg::MASK_OFS) begin
        irq_mask <= pwdata_i[uet_pkg::EV_W-1:0];
      end
    end
  end

  always_comb begin
    next_rdata = uet_pkg::ZERO32;
    next_err   = 1'b0;
    if (paddr_i == uet_pkg::ENV_OFS) begin
      next_rdata[uet_pkg::ENV_M_LSB +: uet_pkg::ENV_W] =
        master_envelope_count;
      next_rdata[uet_pkg::ENV_S_LSB +: uet_pkg::ENV_W] =
        slave_envelope_count;
    end else if (paddr_i == uet_pkg::TMO_OFS) begin
      next_rdata[uet_pkg::TMO_W-1:0] = tmo_limit;
    end else if (paddr_i == uet_pkg::MISC_OFS) begin
      next_rdata[uet_pkg::OVR_BIT] = timing_override_bit;
    end else if (paddr_i == uet_pkg::STAT_OFS) begin
      next_rdata[uet_pkg::EV_W-1:0] = irq_status;
    end else if (paddr_i == uet_pkg::MASK_OFS) begin
      next_rdata[uet_pkg::EV_W-1:0] = irq_mask;
    end else begin
      next_err = 1'b1;
    end
  end

  // Answer one cycle after setup, so every access takes two cycles
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= uet_pkg::ZERO32;
    end else begin
      pready_o  <= rd_setup;
      pslverr_o <= rd_setup & next_err;
      if (rd_setup && !pwrite_i) begin
        prdata_o <= next_rdata;
      end
    end
  end

  // Burst envelope sequencer
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state                   <= uet_pkg::ST_IDLE;
      env_cnt                 <= 4'h0;
      dir_in                  <= 1'b0;
      dma_acknowledge_pin_n_o <= 1'b1;
      host_write_strobe_n_o   <= 1'b1;
      host_read_strobe_n_o    <= 1'b1;
    end else begin
      case (state)
        uet_pkg::ST_IDLE: begin
          if (burst_start_i) begin
            state                   <= uet_pkg::ST_ENV;
            env_cnt                 <= next_env;
            dir_in                  <= burst_data_in_i;
            dma_acknowledge_pin_n_o <= 1'b0;
            host_write_strobe_n_o   <= 1'b0;
            host_read_strobe_n_o    <= 1'b1;
          end
        end
        uet_pkg::ST_ENV: begin
          if (env_done) begin
            state                 <= uet_pkg::ST_BURST;
            host_write_strobe_n_o <= 1'b1;
            host_read_strobe_n_o  <= ~dir_in;
          end else begin
            env_cnt <= env_cnt - 4'h1;
          end
        end
        uet_pkg::ST_BURST: begin
          if (burst_end_i) begin
            state                   <= uet_pkg::ST_IDLE;
            dma_acknowledge_pin_n_o <= 1'b1;
            host_read_strobe_n_o    <= 1'b1;
          end
        end
        default: begin
          state <= uet_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Ready timer; fires once per stretched access
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tmo_cnt       <= 18'h0_0000;
      tmo_fired     <= 1'b0;
      pio_timeout_o <= 1'b0;
    end else begin
      pio_timeout_o <= 1'b0;
      if (!pio_wait_i || io_ready_i || tmo_limit == 18'h0_0000) begin
        tmo_cnt   <= 18'h0_0000;
        tmo_fired <= 1'b0;
      end else if (!tmo_fired) begin
        if (tmo_cnt + 18'h0_0001 == tmo_limit) begin
          tmo_fired     <= 1'b1;
          pio_timeout_o <= 1'b1;
        end else begin
          tmo_cnt <= tmo_cnt + 18'h0_0001;
        end
      end
    end
  end

  assign ev_set = {env_done, pio_timeout_o};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_status <= uet_pkg::EV_RST;
    end else begin
      for (int i = 0; i < uet_pkg::EV_W; i++) begin
        if (ev_set[i]) begin
          irq_status[i] <= 1'b1;
        end else if (wr_en && paddr_i == uet_pkg::STAT_OFS
                     && pwdata_i[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_status | ev_set) & irq_mask);
    end
  end

  // Helper state for the checks below
  logic [4:0] env_seen;
  logic [4:0] env_need;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      env_seen <= 5'h00;
      env_need <= 5'h00;
    end else if (state == uet_pkg::ST_IDLE && burst_start_i) begin
      env_seen <= 5'h00;
      env_need <= {1'b0, next_env} + 5'h01;
    end else if (state == uet_pkg::ST_ENV) begin
      env_seen <= env_seen + 5'h01;
    end
  end

  sequence s_env_end;
    $rose(host_write_strobe_n_o) && state == uet_pkg::ST_BURST;
  endsequence

  sequence s_start;
    state == uet_pkg::ST_IDLE && burst_start_i;
  endsequence

  property p_env_len;
    @(posedge core_clk_i) disable iff (reset_i)
      s_env_end |-> env_seen == env_need && !dma_acknowledge_pin_n_o;
  endproperty

  env_length_a: assert property (p_env_len)
    else $error("envelope length wrong");
  env_read_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_env_end and dir_in |-> $fell(host_read_strobe_n_o))
    else $error("read strobe not asserted after envelope");
  env_write_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_env_end and !dir_in |-> host_read_strobe_n_o)
    else $error("read strobe asserted in data-out burst");
  env_slave_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_start and timing_override_bit && burst_slave_i
    |=> env_need == {1'b0, $past(slave_envelope_count)} + 5'h01)
    else $error("slave envelope not used");
  env_master_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_start and timing_override_bit && !burst_slave_i
    |=> env_need == {1'b0, $past(master_envelope_count)} + 5'h01)
    else $error("master envelope not used");
  env_default_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_start and !timing_override_bit
    |=> env_need == {1'b0, DEFAULT_ENV} + 5'h01)
    else $error("envelope used without override");
  // Read strobe stays idle until the envelope has run out
  env_hold_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    state == uet_pkg::ST_ENV |-> !dma_acknowledge_pin_n_o
      && !host_write_strobe_n_o && host_read_strobe_n_o)
    else $error("strobes changed inside envelope");
  tmo_off_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    tmo_limit == 18'h0_0000 |=> !pio_timeout_o)
    else $error("timeout fired while disabled");
  tmo_fire_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    pio_timeout_o |-> $past(tmo_cnt) + 18'h0_0001 == $past(tmo_limit)
      && $past(pio_wait_i) && !$past(io_ready_i))
    else $error("timeout fired at wrong count");
  tmo_reset_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    !pio_wait_i || io_ready_i |=> tmo_cnt == 18'h0_0000 && !pio_timeout_o)
    else $error("ready timer kept running");
  tmo_sticky_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    pio_timeout_o |=> irq_status[uet_pkg::EV_TMO])
    else $error("timeout flag not set");
  stat_clear_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    wr_en && paddr_i == uet_pkg::STAT_OFS && pwdata_i[uet_pkg::EV_TMO]
      && !ev_set[uet_pkg::EV_TMO] |=> !irq_status[uet_pkg::EV_TMO])
    else $error("timeout flag not cleared");
  rsvd_zero_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    prdata_o[31:18] == 14'h0000)
    else $error("reserved bits read nonzero");

endmodule : uet_top

// *** tb/uet_drive_model.sv ***
`timescale 1ns/1ps
module uet_drive_model (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       pio_wait_i,
  input  wire logic [7:0] hold_i,
  output logic            io_ready_o
);
  logic [7:0] cnt;
  // Drive stretches each wait phase by hold_i cycles
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) cnt <= 8'h00;
    else if (!pio_wait_i) cnt <= 8'h00;
    else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
  end
  // Line is pulled up, so it reads ready once released
  assign io_ready_o = !(pio_wait_i && cnt < hold_i);
endmodule : uet_drive_model

// *** tb/uet_top_tb.sv ***
`timescale 1ns/1ps
module uet_top_tb;
  localparam logic [3:0] DEF_ENV = 4'h5;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } uet_row_t;
  logic        clk, rst, psel, pen, pwr, pready, pslverr;
  logic        bstart, bin, bslave, bend, pwait, rdy;
  logic        ack_n, wr_n, rd_n, tmo, irq, er, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  hold;
  int          failures, num_checks, cyc, n;
  uet_row_t    rows [4];

  uet_top #(.DEFAULT_ENV(DEF_ENV)) i_dut (
    .core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .burst_start_i(bstart), .burst_data_in_i(bin),
    .burst_slave_i(bslave), .burst_end_i(bend), .pio_wait_i(pwait),
    .io_ready_i(rdy), .dma_acknowledge_pin_n_o(ack_n),
    .host_write_strobe_n_o(wr_n), .host_read_strobe_n_o(rd_n),
    .pio_timeout_o(tmo), .irq_o(irq));

  uet_drive_model i_drive (.core_clk_i(clk), .reset_i(rst),
    .pio_wait_i(pwait), .hold_i(hold), .io_ready_o(rdy));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Bounded run, well above the expected few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the bench timeout ends a missing answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic burst(input logic s, input logic din, input int expn);
    int k;
    @(posedge clk);
    bstart <= 1'b1; bslave <= s; bin <= din;
    @(posedge clk);
    bstart <= 1'b0;
    #1 chk("ack low", 32'h0000_0000, 32'(ack_n));
    k = 0;
    while (wr_n !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
      #1;
    end
    chk("envelope cycles", 32'(expn), 32'(k));
    chk("read strobe", 32'(!din), 32'(rd_n));
    @(posedge clk);
    bend <= 1'b1;
    @(posedge clk);
    bend <= 1'b0;
    #1 chk("ack released", 32'h0000_0001, 32'(ack_n));
    chk("read released", 32'h0000_0001, 32'(rd_n));
  endtask : burst

  initial begin
    rows[0] = '{uet_pkg::ENV_OFS, 32'hFFFF_FFFF, 32'h0000_0F0F, 1'b0};
    rows[1] = '{uet_pkg::TMO_OFS, 32'hFFFF_FFFF, 32'h0003_FFFF, 1'b0};
    rows[2] = '{uet_pkg::MISC_OFS, 32'hFFFF_FFFE, 32'h0000_0000, 1'b0};
    rows[3] = '{12'h014, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1};
    {psel, pen, pwr, bstart, bin, bslave, bend, pwait} = 8'h00;
    paddr = 12'h000;
    pwdata = uet_pkg::ZERO32;
    hold = 8'h0A;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, uet_pkg::ENV_OFS, uet_pkg::ZERO32);
    chk("env reset", uet_pkg::ZERO32, rd);
    apb(1'b0, uet_pkg::TMO_OFS, uet_pkg::ZERO32);
    chk("limit reset", uet_pkg::ZERO32, rd);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, uet_pkg::ZERO32);
      chk("readback", rows[i].x, rd);
      chk("slave error", 32'(rows[i].e), 32'(er));
    end
    burst(1'b0, 1'b0, DEF_ENV + 1);
    apb(1'b1, uet_pkg::MISC_OFS, 32'h0000_0001);
    apb(1'b1, uet_pkg::ENV_OFS, 32'h0000_0F00);
    burst(1'b0, 1'b1, 1);
    burst(1'b1, 1'b0, 16);
    apb(1'b1, uet_pkg::ENV_OFS, 32'h0000_0207);
    burst(1'b0, 1'b0, 8);
    burst(1'b1, 1'b1, 3);
    apb(1'b1, uet_pkg::STAT_OFS, 32'h0000_0003);
    apb(1'b1, uet_pkg::MASK_OFS, 32'h0000_0001);
    apb(1'b1, uet_pkg::TMO_OFS, 32'h0000_0003);
    @(posedge clk);
    pwait <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (tmo !== 1'b1 && n < 20);
    chk("timeout cycles", 32'h0000_0003, 32'(n));
    @(posedge clk);
    pwait <= 1'b0;
    #1 chk("pulse width", 32'h0000_0000, 32'(tmo));
    apb(1'b0, uet_pkg::STAT_OFS, uet_pkg::ZERO32);
    chk("status", 32'h0000_0001, rd);
    chk("irq raised", 32'h0000_0001, 32'(irq));
    apb(1'b1, uet_pkg::MASK_OFS, uet_pkg::ZERO32);
    @(posedge clk);
    #1 chk("irq masked", 32'h0000_0000, 32'(irq));
    apb(1'b1, uet_pkg::STAT_OFS, 32'h0000_0001);
    apb(1'b1, uet_pkg::MASK_OFS, 32'h0000_0001);
    @(posedge clk);
    #1 chk("irq cleared", 32'h0000_0000, 32'(irq));
    apb(1'b1, uet_pkg::TMO_OFS, uet_pkg::ZERO32);
    hold <= 8'h28;
    @(posedge clk);
    pwait <= 1'b1;
    seen = 1'b0;
    repeat (30) begin
      @(posedge clk);
      #1 seen = seen | tmo;
    end
    @(posedge clk);
    pwait <= 1'b0;
    chk("disabled timer", 32'h0000_0000, 32'(seen));
    conclude();
  end
endmodule : uet_top_tb
